// File: rtl/vca_defines.svh
`ifndef VCA_DEFINES_SVH
`define VCA_DEFINES_SVH
// What this block does
// - Group arbitration capability reads 00h with no extended channel, 03h with one.
// - Channel table offset in bits 31:24, in 16-byte units, reads 00h or 03h.
// - Writing one to control bit 0 loads the staged table; the bit reads zero.
// - Select field 3:1 resets to 000b; values other than 0 or 1 act as 0.
// - Status bit 16 sets on any table write and clears when a load finishes, unless a table write lands in that same cycle.
// - Resource zero arbitration capability reads the fixed value 09h.
// - Resource zero bit 14 reads zero, so no transaction restriction applies.
// - Resource zero snoop rejection bit 15 always reads zero.
// - Resource zero time slot field 22:16 reads 7Fh.
// - Resource zero port table offset field 31:24 reads 04h.
// - The extended channel count resets to 000b and sideband may override it.

// Register byte addresses.
`define VCA_OFS_CAP2      12'h148
`define VCA_OFS_CTRL      12'h14c
`define VCA_OFS_RES0      12'h150
`define VCA_CAP_BASE      12'h140

// Field positions.
`define VCA_CTRL_LOAD_BIT 0
`define VCA_CTRL_SEL_LSB  1
`define VCA_STAT_PEND_BIT 16
`define VCA_TBLOFS_LSB    24
`define VCA_RES_AS_BIT    14
`define VCA_RES_SNOOP_BIT 15
`define VCA_RES_SLOTS_LSB 16

// Field values.
`define VCA_LPG_CAP_NONE  8'h00
`define VCA_LPG_CAP_ONE   8'h03
`define VCA_TBL_OFS_NONE  8'h00
`define VCA_TBL_OFS_ONE   8'h03
`define VCA_PORT_ARB_CAP  8'h09
`define VCA_MAX_SLOTS     7'h7f
`define VCA_PORT_TBL_OFS  8'h04
`define VCA_EXT_CNT_RST   3'h0
`define VCA_SEL_RST       3'h0
`define VCA_SEL_MAX       3'h1

// Staged table geometry: 32 phases of 4 bits in four words.
`define VCA_TBL_WORDS     4
`define VCA_TBL_IDX_W     2
`endif

// File: rtl/vca_pkg.sv
`include "vca_defines.svh"

package vca_pkg;

  // APB request as driven by the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } vca_apb_req_t;

  // APB answer from this slave.
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vca_apb_rsp_t;

  // Effective channel arbitration scheme.
  typedef enum logic {
    vca_sch_round_robin,
    vca_sch_weighted_rotation
  } vca_scheme_t;

  // Address regions of the register window.
  typedef enum logic [2:0] {
    vca_rg_none,
    vca_rg_cap2,
    vca_rg_ctrl,
    vca_rg_res0,
    vca_rg_table
  } vca_region_t;

  // Table loader states.
  typedef enum logic {
    vca_ld_idle,
    vca_ld_copy
  } vca_load_st_t;

  typedef struct packed {
    vca_load_st_t               st;
    logic [`VCA_TBL_IDX_W-1:0]  idx;
    logic                       done;
  } vca_loader_state_t;

  typedef logic [`VCA_TBL_WORDS-1:0][31:0] vca_table_t;

  typedef struct packed {
    logic [2:0]   ext_count;
    logic [2:0]   arb_select;
    vca_scheme_t  scheme;
    logic         table_pending;
    logic         load_req;
    vca_table_t   staging;
    vca_table_t   active;
    vca_apb_rsp_t rsp;
  } vca_state_t;

endpackage : vca_pkg

// File: rtl/vca_table_loader.sv
`timescale 1ns/1ps
`include "vca_defines.svh"

module vca_table_loader #(
  parameter int ENTRIES = `VCA_TBL_WORDS
) (
  // Clock and reset.
  input  logic                      i_clk,
  input  logic                      i_sys_rst,
  // Load command.
  input  logic                      i_start,
  // Copy sequence.
  output logic                      o_busy,
  output logic                      o_copy_en,
  output logic [`VCA_TBL_IDX_W-1:0] o_copy_idx,
  output logic                      o_done
);

  localparam logic [`VCA_TBL_IDX_W-1:0] LAST =
    `VCA_TBL_IDX_W'(ENTRIES - 1);

  vca_pkg::vca_loader_state_t q;
  vca_pkg::vca_loader_state_t next_q;

  // Walk the entries one per cycle; a start while busy is ignored.
  always_comb
  begin
    next_q = q;
    next_q.done = 1'b0;
    unique case (q.st)
      vca_pkg::vca_ld_idle:
      begin
        if (i_start)
        begin
          next_q.st = vca_pkg::vca_ld_copy;
          next_q.idx = '0;
        end
      end
      vca_pkg::vca_ld_copy:
      begin
        if (q.idx == LAST)
        begin
          next_q.st = vca_pkg::vca_ld_idle;
          next_q.done = 1'b1;
        end
        else
        begin
          next_q.idx = q.idx + 1'b1;
        end
      end
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      q <= '{st: vca_pkg::vca_ld_idle, idx: '0, done: 1'b0};
    else
      q <= next_q;
  end

  // Sequence outputs.
  assign o_busy     = (q.st == vca_pkg::vca_ld_copy);
  assign o_copy_en  = (q.st == vca_pkg::vca_ld_copy);
  assign o_copy_idx = q.idx;
  assign o_done     = q.done;

endmodule : vca_table_loader

// File: rtl/vca_config_regs.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "vca_defines.svh"

module vca_config_regs (
  // Clock and reset.
  input  logic                          i_clk,
  input  logic                          i_sys_rst,
  // APB register port.
  input  vca_pkg::vca_apb_req_t         i_apb,
  output vca_pkg::vca_apb_rsp_t         o_apb,
  // Sideband override of the extended channel count.
  input  logic                          i_sideband_count_wr,
  input  logic [2:0]                    i_sideband_count,
  // Arbitration configuration towards the datapath.
  output logic [2:0]                    o_ext_channel_count,
  output vca_pkg::vca_scheme_t          o_arb_scheme,
  output vca_pkg::vca_table_t           o_active_table,
  output logic                          o_table_pending,
  output logic                          o_table_loading
);

  vca_pkg::vca_state_t q;
  vca_pkg::vca_state_t next_q;

  // Loader handshake.
  logic                      ld_busy;
  logic                      ld_copy_en;
  logic [`VCA_TBL_IDX_W-1:0] ld_copy_idx;
  logic                      ld_done;

  // Bus phase decode.
  logic                      setup;
  logic                      access;
  logic                      table_wr;
  vca_pkg::vca_region_t      region;
  logic [`VCA_TBL_IDX_W-1:0] word_idx;

  // A nonzero count is treated as the one extended channel supported.
  function automatic logic has_ext(input logic [2:0] cnt);
    has_ext = (cnt != `VCA_EXT_CNT_RST);
  endfunction : has_ext

  // Table offset field, in 16-byte units from the capability base.
  function automatic logic [7:0] table_ofs(input logic [2:0] cnt);
    if (has_ext(cnt))
      table_ofs = `VCA_TBL_OFS_ONE;
    else
      table_ofs = `VCA_TBL_OFS_NONE;
  endfunction : table_ofs

  // Decode a byte address into a register region.
  function automatic vca_pkg::vca_region_t decode(
    input logic [11:0] addr,
    input logic [2:0]  cnt
  );
    logic [11:0] base;
    base = `VCA_CAP_BASE + {table_ofs(cnt), 4'h0};
    if (addr[11:2] == `VCA_OFS_CAP2 >> 2)
      decode = vca_pkg::vca_rg_cap2;
    else if (addr[11:2] == `VCA_OFS_CTRL >> 2)
      decode = vca_pkg::vca_rg_ctrl;
    else if (addr[11:2] == `VCA_OFS_RES0 >> 2)
      decode = vca_pkg::vca_rg_res0;
    else if (has_ext(cnt) && addr[11:4] == base[11:4])
      decode = vca_pkg::vca_rg_table;
    else
      decode = vca_pkg::vca_rg_none;
  endfunction : decode

  // Port capability word two.
  function automatic logic [31:0] cap2_word(input logic [2:0] cnt);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (has_ext(cnt))
      w[7:0] = `VCA_LPG_CAP_ONE;
    else
      w[7:0] = `VCA_LPG_CAP_NONE;
    w[`VCA_TBLOFS_LSB +: 8] = table_ofs(cnt);
    cap2_word = w;
  endfunction : cap2_word

  // Resource zero capability word; every field is fixed.
  function automatic logic [31:0] res0_word();
    logic [31:0] w;
    w = 32'h0000_0000;
    w[7:0] = `VCA_PORT_ARB_CAP;
    w[`VCA_RES_AS_BIT] = 1'b0;
    w[`VCA_RES_SNOOP_BIT] = 1'b0;
    w[`VCA_RES_SLOTS_LSB +: 7] = `VCA_MAX_SLOTS;
    w[`VCA_TBLOFS_LSB +: 8] = `VCA_PORT_TBL_OFS;
    res0_word = w;
  endfunction : res0_word

  // Shared control and status word; the load bit never reads back.
  function automatic logic [31:0] ctrl_word(
    input logic [2:0] sel,
    input logic       pend
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VCA_CTRL_LOAD_BIT] = 1'b0;
    w[`VCA_CTRL_SEL_LSB +: 3] = sel;
    w[`VCA_STAT_PEND_BIT] = pend;
    ctrl_word = w;
  endfunction : ctrl_word

  // Out-of-range select values fall back to the default scheme.
  function automatic vca_pkg::vca_scheme_t scheme_of(
    input logic [2:0] sel
  );
    if (sel == `VCA_SEL_MAX)
      scheme_of = vca_pkg::vca_sch_weighted_rotation;
    else
      scheme_of = vca_pkg::vca_sch_round_robin;
  endfunction : scheme_of

  // Merge write data into a word under the byte strobes.
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        w[b*8 +: 8] = wdata[b*8 +: 8];
    end
    merge = w;
  endfunction : merge

  // Phase and region decode shared by read and write paths.
  always_comb
  begin
    setup    = i_apb.psel && !i_apb.penable;
    access   = i_apb.psel && i_apb.penable && q.rsp.pready;
    region   = decode(i_apb.paddr, q.ext_count);
    word_idx = i_apb.paddr[`VCA_TBL_IDX_W+1:2];
    table_wr = access && i_apb.pwrite && !q.rsp.pslverr &&
               (region == vca_pkg::vca_rg_table);
  end

  // Next state. Read data is captured in the setup cycle so that the
  // answer comes from a flop, with no wait state: pready rises in the first access cycle.
  always_comb
  begin
    next_q = q;
    next_q.load_req = 1'b0;
    next_q.rsp.pready = setup;
    next_q.rsp.pslverr = 1'b0;

    // Read data and error for the coming access phase.
    if (setup)
    begin
      next_q.rsp.pslverr = (region == vca_pkg::vca_rg_none);
      next_q.rsp.prdata = 32'h0000_0000;
      if (!i_apb.pwrite)
      begin
        unique case (region)
          vca_pkg::vca_rg_none:
            next_q.rsp.prdata = 32'h0000_0000;
          vca_pkg::vca_rg_cap2:
            next_q.rsp.prdata = cap2_word(q.ext_count);
          vca_pkg::vca_rg_ctrl:
            next_q.rsp.prdata = ctrl_word(q.arb_select,
                                          q.table_pending);
          vca_pkg::vca_rg_res0:
            next_q.rsp.prdata = res0_word();
          vca_pkg::vca_rg_table:
            next_q.rsp.prdata = q.staging[word_idx];
        endcase
      end
    end

    // Control writes; only byte lane zero holds writable fields.
    if (access && i_apb.pwrite && !q.rsp.pslverr &&
        region == vca_pkg::vca_rg_ctrl && i_apb.pstrb[0])
    begin
      next_q.arb_select =
        i_apb.pwdata[`VCA_CTRL_SEL_LSB +: 3];
      next_q.scheme =
        scheme_of(i_apb.pwdata[`VCA_CTRL_SEL_LSB +: 3]);
      next_q.load_req = i_apb.pwdata[`VCA_CTRL_LOAD_BIT];
    end

    // Table entry writes go to the staging copy only.
    if (table_wr)
    begin
      next_q.staging[word_idx] = merge(q.staging[word_idx],
                                       i_apb.pwdata,
                                       i_apb.pstrb);
    end

    // Loader copies one staged word per cycle into the live table.
    if (ld_copy_en)
    begin
      next_q.active[ld_copy_idx] = q.staging[ld_copy_idx];
    end

    // Pending flag: a write in the finishing cycle keeps it set.
    if (ld_done)
      next_q.table_pending = 1'b0;
    if (table_wr)
      next_q.table_pending = 1'b1;

    // Sideband management may replace the count at any time.
    if (i_sideband_count_wr)
      next_q.ext_count = i_sideband_count;
  end

  // State register with synchronous reset.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      q <= '{ext_count:     `VCA_EXT_CNT_RST,
             arb_select:    `VCA_SEL_RST,
             scheme:        vca_pkg::vca_sch_round_robin,
             table_pending: 1'b0,
             load_req:      1'b0,
             staging:       '0,
             active:        '0,
             rsp:           '0};
    end
    else
    begin
      q <= next_q;
    end
  end

  // Sequencer that applies the staged table.
  vca_table_loader #(
    .ENTRIES (`VCA_TBL_WORDS)
  ) u_loader (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_start    (q.load_req),
    .o_busy     (ld_busy),
    .o_copy_en  (ld_copy_en),
    .o_copy_idx (ld_copy_idx),
    .o_done     (ld_done)
  );

  // Outputs.
  assign o_apb               = q.rsp;
  assign o_ext_channel_count = q.ext_count;
  assign o_arb_scheme        = q.scheme;
  assign o_active_table      = q.active;
  assign o_table_pending     = q.table_pending;
  assign o_table_loading     = ld_busy;

endmodule : vca_config_regs

// File: test/vca_config_regs_sva.sv
`timescale 1ns/1ps
module vca_config_regs_sva (
  // Clock and reset.
  input logic                  i_clk,
  input logic                  i_sys_rst,
  // Register port.
  input vca_pkg::vca_apb_req_t i_apb,
  input vca_pkg::vca_apb_rsp_t o_apb,
  // Sideband and datapath side.
  input logic                  i_sideband_count_wr,
  input logic [2:0]            i_sideband_count,
  input logic [2:0]            o_ext_channel_count,
  input vca_pkg::vca_scheme_t  o_arb_scheme,
  input vca_pkg::vca_table_t   o_active_table,
  input logic                  o_table_pending,
  input logic                  o_table_loading
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // A transfer completes where pready meets an access phase.
  logic acc;
  logic wr;
  logic rd;
  assign acc = i_apb.psel & i_apb.penable & o_apb.pready;
  assign wr  = acc & i_apb.pwrite;
  assign rd  = acc & ~i_apb.pwrite;

  // A load is a command, then a burst of copy cycles.
  sequence s_load_cmd;
    wr && i_apb.paddr == 12'h14c && i_apb.pwdata[0] && i_apb.pstrb[0]
      && !o_table_loading;
  endsequence
  sequence s_copy;
    ##[1:3] o_table_loading [*3];
  endsequence
  sequence s_tbl_wr;
    wr && i_apb.paddr[11:4] == 8'h17 && o_ext_channel_count != 3'h0;
  endsequence

  chk_load_copy: assert property (s_load_cmd |-> s_copy)
    else $error("table load did not run");
  chk_pend_set: assert property (s_tbl_wr |=> o_table_pending)
    else $error("pending not set by table write");
  chk_pend_clear: assert property ($fell(o_table_loading)
    |-> ##[0:2] !o_table_pending) else $error("pending not cleared");
  chk_scheme_sel: assert property (wr && i_apb.paddr == 12'h14c
    && i_apb.pstrb[0] |=> o_arb_scheme ==
    ($past(i_apb.pwdata[3:1]) == 3'h1)) else $error("scheme wrong");
  chk_rst_clear: assert property ($fell(i_sys_rst)
    |-> o_ext_channel_count == 3'h0 && !o_table_pending
    && o_arb_scheme == vca_pkg::vca_sch_round_robin)
    else $error("reset value wrong");
  chk_cap_word: assert property (rd && i_apb.paddr == 12'h148
    |-> o_apb.prdata == (($past(o_ext_channel_count) != 3'h0)
    ? 32'h03000003 : 32'h00000000)) else $error("capability word wrong");
  chk_res_word: assert property (rd && i_apb.paddr == 12'h150
    |-> o_apb.prdata == 32'h047f0009) else $error("resource word wrong");
  chk_ctrl_word: assert property (rd && i_apb.paddr == 12'h14c
    |-> o_apb.prdata[0] == 1'b0 && o_apb.prdata[15:4] == 12'h000
    && o_apb.prdata[31:17] == 15'h0000
    && o_apb.prdata[16] == $past(o_table_pending))
    else $error("control word wrong");
  chk_count_load: assert property (i_sideband_count_wr
    |=> o_ext_channel_count == $past(i_sideband_count))
    else $error("count not loaded");
  // No wait state, and pready never lingers.
  chk_ready_pulse: assert property (i_apb.psel && !i_apb.penable
    |=> o_apb.pready ##1 !o_apb.pready) else $error("pready timing");
endmodule : vca_config_regs_sva

bind vca_config_regs vca_config_regs_sva u_sva (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_apb(o_apb),
  .i_sideband_count_wr(i_sideband_count_wr),
  .i_sideband_count(i_sideband_count),
  .o_ext_channel_count(o_ext_channel_count), .o_arb_scheme(o_arb_scheme),
  .o_active_table(o_active_table), .o_table_pending(o_table_pending),
  .o_table_loading(o_table_loading));

// File: test/tb_vca_config_regs.sv
`timescale 1ns/1ps
module tb_vca_config_regs;
  logic                  i_clk     = 1'b0;
  logic                  i_sys_rst = 1'b1;
  vca_pkg::vca_apb_req_t req       = '0;
  vca_pkg::vca_apb_rsp_t rsp;
  logic                  sbw       = 1'b0;
  logic [2:0]            sbc       = 3'h0;
  logic [2:0]            cnt;
  vca_pkg::vca_scheme_t  sch;
  vca_pkg::vca_table_t   tbl;
  logic                  pend;
  logic                  ldg;
  logic [31:0]           rd;
  logic                  er;
  int                    mismatches      = 0;
  int                    samples_checked = 0;

  // Free-running 250 MHz clock.
  initial
  begin
    forever #2 i_clk = ~i_clk;
  end

  vca_config_regs DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_apb(req), .o_apb(rsp), .i_sideband_count_wr(sbw),
    .i_sideband_count(sbc), .o_ext_channel_count(cnt),
    .o_arb_scheme(sch), .o_active_table(tbl), .o_table_pending(pend),
    .o_table_loading(ldg));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One transfer; the request stays put until pready is sampled high.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d,
             pstrb:4'hf};
    @(posedge i_clk);
    req.penable <= 1'b1;
    @(posedge i_clk);
    while (rsp.pready !== 1'b1)
      @(posedge i_clk);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask : xfer

  task stop_test;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // The tests need about 110 cycles, so this is ample margin.
  initial
  begin
    repeat (4000) @(posedge i_clk);
    mismatches++;
    stop_test();
  end

  // Reset, then registers, sideband count, scheme select and table load.
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    xfer(1'b0, 12'h148, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, 12'h14c, 32'h0);
    chk(rd, 32'h0);
    chk(32'(cnt), 32'h0);
    xfer(1'b1, 12'h150, 32'hffffffff);
    xfer(1'b0, 12'h150, 32'h0);
    chk(rd, 32'h047f0009);
    xfer(1'b1, 12'h148, 32'hffffffff);
    xfer(1'b0, 12'h148, 32'h0);
    chk(rd, 32'h0);
    // Hidden table window and an unmapped word both refuse.
    xfer(1'b0, 12'h170, 32'h0);
    chk(32'(er), 32'h1);
    xfer(1'b0, 12'h004, 32'h0);
    chk(32'(er), 32'h1);
    @(posedge i_clk);
    sbw <= 1'b1;
    sbc <= 3'h1;
    @(posedge i_clk);
    sbw <= 1'b0;
    xfer(1'b0, 12'h148, 32'h0);
    chk(rd, 32'h03000003);
    chk(32'(cnt), 32'h1);
    for (int s = 0; s < 8; s++)
    begin
      xfer(1'b1, 12'h14c, 32'(s << 1));
      xfer(1'b0, 12'h14c, 32'h0);
      chk(rd, 32'(s << 1));
      chk(32'(sch), 32'(s == 1));
    end
    for (int i = 0; i < 4; i++)
      xfer(1'b1, 12'h170 + 12'(4 * i), 32'(32'h11111111 * (i + 1)));
    chk(32'(pend), 32'h1);
    xfer(1'b0, 12'h14c, 32'h0);
    chk(rd, 32'h0001000e);
    xfer(1'b1, 12'h14c, 32'h1);
    // The loader starts one edge after the command and copies for four.
    repeat (2) @(posedge i_clk);
    chk(32'(ldg), 32'h1);
    repeat (6) @(posedge i_clk);
    chk(32'(ldg), 32'h0);
    chk(32'(pend), 32'h0);
    for (int i = 0; i < 4; i++)
      chk(tbl[i], 32'(32'h11111111 * (i + 1)));
    xfer(1'b0, 12'h14c, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : tb_vca_config_regs
